/* File: hw/lbt_pkg.sv */
package lbt_pkg;

	// ****************************************
	// Bus widths and codes
	// ****************************************
	localparam int          ADDR_W       = 32;
	localparam int          DATA_W       = 32;
	localparam logic [1:0]  FC_DATA      = 2'h1;
	localparam logic [31:0] RAM_TOP      = 32'h0400_0000;
	localparam logic [2:0]  BURST_BEATS  = 3'h4;
	localparam logic [1:0]  MIN_BEAT_CLK = 2'h2;
	localparam logic [1:0]  SIZE_LONG    = 2'h0;
	localparam logic [1:0]  SIZE_BYTE    = 2'h1;
	localparam logic [1:0]  SIZE_WORD    = 2'h2;
	localparam logic [3:0]  RETRY_MAX    = 4'h8;
	localparam logic [1:0]  ACK_BYTE     = 2'h1;
	localparam logic [1:0]  ACK_WORD     = 2'h2;
	localparam logic [1:0]  ACK_LONG     = 2'h3;

	// ****************************************
	// Host cycle results
	// ****************************************
	localparam logic [1:0] RES_OK    = 2'h0;
	localparam logic [1:0] RES_ERROR = 2'h1;
	localparam logic [1:0] RES_RETRY = 2'h2;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_CYCLE = 5'b00010,
		ST_WAIT  = 5'b00100,
		ST_DONE  = 5'b01000,
		ST_YIELD = 5'b10000
	} lbt_state_t;

	typedef enum logic [2:0] {
		SL_IDLE = 3'b001,
		SL_WAIT = 3'b010,
		SL_ANS  = 3'b100
	} lbt_slot_state_t;

endpackage

/* File: hw/lbt_slot_if.sv */
`timescale 1ns/10ps
interface lbt_slot_if;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [1:0]  size;
	logic        rw;
	logic        strobe_n;
	logic        burst_request_n;
	logic        burst_ack_n;
	logic [1:0]  async_size_ack_n;
	logic        sync_terminate_n;
	logic        bus_error_n;
	logic        halt_n;
	logic [1:0]  fc;
	logic        cache_inhibit_out_n;
	logic        bus_request_n;
	logic        bus_grant_n;
	logic        locked_cycle_n;

	modport translator (
		output addr, wdata, size, rw, strobe_n, burst_request_n, fc, cache_inhibit_out_n, bus_grant_n,
		       locked_cycle_n,
		input  rdata, burst_ack_n, async_size_ack_n, sync_terminate_n, bus_error_n, halt_n, bus_request_n
	);
	modport card (
		input  addr, wdata, size, rw, strobe_n, burst_request_n, fc, cache_inhibit_out_n, bus_grant_n,
		       locked_cycle_n,
		output rdata, burst_ack_n, async_size_ack_n, sync_terminate_n, bus_error_n, halt_n, bus_request_n
	);
endinterface

/* File: hw/lbt_bus_translator.sv */
`timescale 1ns/10ps
// Function
// R1 - Error or retry only with normal termination
// R2 - Lone bus error uses async ack timing
// R3 - Error with sync terminate, same edge
// R4 - Halt alone neither ends nor stops
// R5 - Burst ack means four wrapping longwords
// R6 - Retry after first beat becomes error
// R7 - Burst beats take two clocks minimum
// R8 - No coprocessor interface cycles
// R9 - Host owns bus: function code data
// R10 - Cache inhibit output held low
// R11 - No cycle start, FC2, buffer enable pins
// R12 - No interrupt acknowledge cycles on slot
// R13 - No breakpoint acknowledge cycles on slot
// R14 - Masters expect no fast bus grant
// R15 - No relinquish-retry during sizing or lock
// R16 - Cards expect no bursts from own space
// R17 - Masters get no burst ack to memory
// R18 - Host cycles translated, acknowledge cycles not
// R19 - Size narrow cycles, route and smear lanes; a word written to a byte port repeats its high byte on the second beat
// R20 - Burst writes only below 64 MB
// R21 - Retry serviced locally, relinquish on deadlock
module lbt_bus_translator (
	// ****************************************
	// Clock and reset
	// ****************************************
	input  wire logic        clk,
	input  wire logic        reset,
	// ****************************************
	// Host request
	// ****************************************
	input  wire logic        hostReq,
	input  wire logic [31:0] hostAddr,
	input  wire logic [31:0] hostWdata,
	input  wire logic [1:0]  hostSize,
	input  wire logic        hostRw,
	input  wire logic        hostBurst,
	input  wire logic        hostAckCycle,
	input  wire logic        hostLocked,
	// ****************************************
	// Host answer
	// ****************************************
	output logic             hostBusy,
	output logic             hostDone,
	output logic [1:0]       hostResult,
	output logic [31:0]      hostRdata,
	output logic [2:0]       hostBeat,
	output logic             hostGranted,
	// ****************************************
	// Slot
	// ****************************************
	lbt_slot_if.translator   slot
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		lbt_pkg::lbt_state_t st;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic [1:0]  size;
		logic        rw;
		logic        burst;
		logic        locked;
		logic [1:0]  offs;
		logic [2:0]  beat;
		logic [1:0]  beatClk;
		logic [3:0]  retries;
		logic        strobeN;
		logic        burstReqN;
		logic        grantN;
		logic        done;
		logic [1:0]  result;
		logic [31:0] outRdata;
		logic [2:0]  outBeat;
		logic        busy;
	} lbt_xlat_t;

	lbt_xlat_t s_q;
	lbt_xlat_t s_d;

	logic       errSeen;
	logic       retrySeen;
	logic       termSeen;
	logic [1:0] portWidth;
	logic [1:0] remain;
	logic [1:0] step;
	logic [1:0] curByte;
	logic [4:0] wrShift;
	logic [5:0] rdShift;

	always_comb begin
		// Error only counts with halt-less or halt; halt alone is never a termination
		errSeen   = !slot.bus_error_n; // R1 R2 R3
		retrySeen = !slot.bus_error_n && !slot.halt_n;
		termSeen  = !slot.sync_terminate_n || (slot.async_size_ack_n != 2'h3) || errSeen; // R4
		portWidth = !slot.sync_terminate_n ? lbt_pkg::ACK_LONG : ~slot.async_size_ack_n;
		remain    = s_q.size - s_q.offs;
		step      = (portWidth == lbt_pkg::ACK_BYTE) ? 2'h1 : (portWidth == lbt_pkg::ACK_WORD) ? 2'h2 : 2'h0;
		// Lane placement follows the byte address of this beat, not just the offset
		curByte   = s_q.addr[1:0] + s_q.offs;
		wrShift   = {s_q.offs, 3'h0};
		rdShift   = {(3'h4 - {1'b0, curByte} - {1'b0, step}), 3'h0};
	end

	always_comb begin
		s_d      = s_q;
		s_d.done = 1'b0;
		unique case (s_q.st)
			lbt_pkg::ST_IDLE: begin
				s_d.grantN = !(slot.bus_request_n == 1'b0 && !hostReq);
				// Acknowledge cycles are answered at once and never reach the slot
				if (hostReq && hostAckCycle && s_q.grantN) begin
					s_d.done   = 1'b1; // R12 R13 R18
					s_d.result = lbt_pkg::RES_OK;
				end else if (hostReq && s_q.grantN && slot.bus_request_n) begin
					s_d.st      = lbt_pkg::ST_CYCLE; // R18
					s_d.addr    = hostAddr;
					s_d.wdata   = hostWdata;
					s_d.size    = hostSize;
					s_d.rw      = hostRw;
					s_d.locked  = hostLocked;
					s_d.burst   = hostBurst && (hostRw || hostAddr < lbt_pkg::RAM_TOP); // R20
					s_d.offs    = 2'h0;
					s_d.beat    = 3'h0;
					s_d.retries = 4'h0;
					s_d.rdata   = 32'h0000_0000;
					s_d.busy    = 1'b1;
				end
			end
			lbt_pkg::ST_CYCLE: begin
				s_d.strobeN   = 1'b0;
				s_d.burstReqN = !s_q.burst;
				s_d.beatClk   = 2'h1;
				s_d.st        = lbt_pkg::ST_WAIT;
			end
			lbt_pkg::ST_WAIT: begin
				if (s_q.beatClk != 2'h3) begin
					s_d.beatClk = s_q.beatClk + 2'h1;
				end
				if (termSeen && s_q.beatClk >= lbt_pkg::MIN_BEAT_CLK - 2'h1) begin // R7
					s_d.strobeN = 1'b1;
					s_d.burstReqN = 1'b1;
					if (retrySeen && s_q.beat == 3'h0) begin
						s_d.retries = s_q.retries + 4'h1; // R21
						s_d.st = (s_q.retries + 4'h1 >= lbt_pkg::RETRY_MAX && !s_q.locked && s_q.offs == 2'h0)
						         ? lbt_pkg::ST_YIELD : lbt_pkg::ST_CYCLE; // R15
					end else if (errSeen) begin
						s_d.result = lbt_pkg::RES_ERROR; // R6
						s_d.st     = lbt_pkg::ST_DONE;
					end else begin
						// Narrow port data arrives on the high lanes and moves to the addressed lanes
						if (step == 2'h0) begin
							s_d.rdata = slot.rdata;
						end else begin
							s_d.rdata = s_q.rdata | ((step == 2'h1 ? {24'h00_0000, slot.rdata[31:24]}
							                                        : {16'h0000, slot.rdata[31:16]})
							                         << rdShift); // R19
						end
						if (!slot.burst_ack_n && s_q.burst && s_q.beat < lbt_pkg::BURST_BEATS - 3'h1) begin
							s_d.beat  = s_q.beat + 3'h1; // R5
							s_d.addr  = {s_q.addr[31:4], s_q.addr[3:2] + 2'h1, s_q.addr[1:0]};
							s_d.st    = lbt_pkg::ST_CYCLE;
						end else if (step != 2'h0 && (remain == 2'h0 || remain > step)) begin // R19
							s_d.offs = s_q.offs + step;
							s_d.st   = lbt_pkg::ST_CYCLE;
						end else begin
							s_d.result = lbt_pkg::RES_OK;
							s_d.st     = lbt_pkg::ST_DONE;
						end
					end
				end
			end
			lbt_pkg::ST_YIELD: begin
				// Give the bus to a waiting master, then retry from scratch
				s_d.grantN  = slot.bus_request_n;
				s_d.retries = 4'h0; // R21
				if (slot.bus_request_n) begin
					s_d.st = lbt_pkg::ST_CYCLE;
				end
			end
			lbt_pkg::ST_DONE: begin
				s_d.done     = 1'b1;
				s_d.busy     = 1'b0;
				s_d.outRdata = s_q.rdata;
				s_d.outBeat  = s_q.beat;
				s_d.st       = lbt_pkg::ST_IDLE;
			end
			default: s_d.st = lbt_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_q <= '{st: lbt_pkg::ST_IDLE, strobeN: 1'b1, burstReqN: 1'b1, grantN: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign hostBusy    = s_q.busy;
	assign hostDone    = s_q.done;
	assign hostResult  = s_q.result;
	assign hostRdata   = s_q.outRdata;
	assign hostBeat    = s_q.outBeat;
	assign hostGranted = !s_q.grantN;

	assign slot.addr     = {s_q.addr[31:2], s_q.addr[1:0] + s_q.offs};
	// Writes are smeared so each port width finds its bytes on its own lanes, except a word written to a byte port, whose second beat repeats the high byte
	assign slot.wdata    = (s_q.size == lbt_pkg::SIZE_BYTE) ? {4{s_q.wdata[7:0]}} :
	                       (s_q.size == lbt_pkg::SIZE_WORD) ? {2{s_q.wdata[15:0]}} :
	                       (s_q.wdata << wrShift); // R19
	assign slot.size     = s_q.size - s_q.offs;
	assign slot.rw       = s_q.rw;
	assign slot.strobe_n = s_q.strobeN;
	assign slot.burst_request_n = s_q.burstReqN;
	// Only data-space cycles exist; no coprocessor or acknowledge space is ever coded
	assign slot.fc       = s_q.grantN ? lbt_pkg::FC_DATA : 2'h0; // R8 R9
	assign slot.cache_inhibit_out_n = 1'b0; // R10 R11
	assign slot.bus_grant_n    = s_q.grantN;
	assign slot.locked_cycle_n = !(s_q.locked && s_q.busy);

endmodule

/* File: hw/lbt_slot_card.sv */
`timescale 1ns/10ps
module lbt_slot_card #(
	parameter int WAIT_CLK = 1
) (
	// ****************************************
	// Clock and reset
	// ****************************************
	input  wire logic        clk,
	input  wire logic        reset,
	// ****************************************
	// Card user side
	// ****************************************
	input  wire logic [31:0] cardRdata,
	input  wire logic        cardBurstCapable,
	input  wire logic        cardSync,
	input  wire logic [1:0]  cardAckWidth,
	input  wire logic        cardError,
	input  wire logic        cardRetry,
	input  wire logic        cardWantBus,
	output logic             cardWrite,
	output logic [31:0]      cardAddr,
	output logic [31:0]      cardWdata,
	output logic             cardOwnsBus,
	// ****************************************
	// Slot
	// ****************************************
	lbt_slot_if.card         slot
);

	typedef struct packed {
		lbt_pkg::lbt_slot_state_t st;
		logic [1:0]  waitCnt;
		logic [31:0] rdata;
		logic        syncN;
		logic [1:0]  asyncN;
		logic        errN;
		logic        haltN;
		logic        burstAckN;
		logic        reqN;
		logic        write;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        owns;
	} lbt_card_t;

	lbt_card_t s_q;
	lbt_card_t s_d;

	always_comb begin
		s_d           = s_q;
		s_d.write     = 1'b0;
		s_d.reqN      = !cardWantBus; // R14 R15
		s_d.owns      = !slot.bus_grant_n && cardWantBus;
		unique case (s_q.st)
			lbt_pkg::SL_IDLE: begin
				if (!slot.strobe_n) begin
					s_d.waitCnt = 2'h0;
					s_d.addr    = slot.addr;
					s_d.wdata   = slot.wdata;
					s_d.st      = lbt_pkg::SL_WAIT;
				end
			end
			lbt_pkg::SL_WAIT: begin
				s_d.waitCnt = s_q.waitCnt + 2'h1;
				if (32'(s_q.waitCnt) + 1 >= WAIT_CLK) begin
					// Error and retry are driven together with the termination, never later
					s_d.rdata     = cardRdata;
					s_d.syncN     = !cardSync; // R1 R3
					s_d.asyncN    = cardSync ? 2'h3 : ~cardAckWidth; // R2
					s_d.errN      = !(cardError || cardRetry);
					s_d.haltN     = !cardRetry; // R4
					// Burst ack only for bursts this card can complete in full
					s_d.burstAckN = !(cardBurstCapable && !slot.burst_request_n); // R5 R16 R17
					s_d.write     = !slot.rw;
					s_d.st        = lbt_pkg::SL_ANS;
				end
			end
			lbt_pkg::SL_ANS: begin
				// One answer clock plus the wait clock keeps each beat at two clocks or more
				s_d.syncN     = 1'b1; // R7
				s_d.asyncN    = 2'h3;
				s_d.errN      = 1'b1;
				s_d.haltN     = 1'b1;
				s_d.burstAckN = 1'b1;
				if (slot.strobe_n) begin
					s_d.st = lbt_pkg::SL_IDLE;
				end
			end
			default: s_d.st = lbt_pkg::SL_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_q <= '{st: lbt_pkg::SL_IDLE, syncN: 1'b1, asyncN: 2'h3, errN: 1'b1, haltN: 1'b1,
			         burstAckN: 1'b1, reqN: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign slot.rdata            = s_q.rdata;
	assign slot.sync_terminate_n = s_q.syncN;
	assign slot.async_size_ack_n = s_q.asyncN;
	assign slot.bus_error_n      = s_q.errN; // R6
	assign slot.halt_n           = s_q.haltN;
	assign slot.burst_ack_n      = s_q.burstAckN;
	assign slot.bus_request_n    = s_q.reqN;
	assign cardWrite             = s_q.write;
	assign cardAddr              = s_q.addr;
	assign cardWdata             = s_q.wdata;
	assign cardOwnsBus           = s_q.owns;

endmodule

/* File: tb/lbt_checker.sv */
`timescale 1ns/10ps
module lbt_checker (
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// Slot signals
	input wire logic [31:0] addr,
	input wire logic        rw,
	input wire logic        strobe_n,
	input wire logic        burst_request_n,
	input wire logic [1:0]  async_size_ack_n,
	input wire logic        sync_terminate_n,
	input wire logic        bus_error_n,
	input wire logic        halt_n,
	input wire logic [1:0]  fc,
	input wire logic        cache_inhibit_out_n,
	input wire logic        bus_grant_n
);
	// ****************************************
	// Slot protocol properties
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_fc_data;
		bus_grant_n |-> fc == lbt_pkg::FC_DATA;
	endproperty
	a_fc_data: assert property (p_fc_data) else $error("function code not data");

	property p_ci_low;
		cache_inhibit_out_n == 1'h0;
	endproperty
	a_ci_low: assert property (p_ci_low) else $error("cache inhibit out high");

	// A single cycle must release its strobe right after a sync or async termination
	property p_ack_ends;
		!strobe_n && burst_request_n && (!sync_terminate_n || async_size_ack_n != 2'h3) |=> strobe_n;
	endproperty
	a_ack_ends: assert property (p_ack_ends) else $error("cycle not ended by termination");

	property p_halt_alone;
		!strobe_n && !halt_n && bus_error_n && sync_terminate_n && async_size_ack_n == 2'h3 |=> !strobe_n;
	endproperty
	a_halt_alone: assert property (p_halt_alone) else $error("halt alone ended cycle");

	property p_burst_write;
		!burst_request_n && !rw |-> addr < lbt_pkg::RAM_TOP;
	endproperty
	a_burst_write: assert property (p_burst_write) else $error("burst write above ram");

	property p_sync_gap;
		!sync_terminate_n |=> sync_terminate_n;
	endproperty
	a_sync_gap: assert property (p_sync_gap) else $error("one clock sync beat");

	property p_async_gap;
		async_size_ack_n != 2'h3 |=> async_size_ack_n == 2'h3;
	endproperty
	a_async_gap: assert property (p_async_gap) else $error("one clock async beat");

	property p_bus_error_n_in_cycle;
		!bus_error_n |-> !strobe_n;
	endproperty
	a_bus_error_n_in_cycle: assert property (p_bus_error_n_in_cycle) else $error("bus error outside cycle");

	c_burst: cover property (!burst_request_n && !sync_terminate_n);
	c_error: cover property (!bus_error_n && halt_n);
	c_grant: cover property (!bus_grant_n);
endmodule

/* File: tb/tb.sv */
`timescale 1ns/10ps
module tb;
	logic        clk, reset, hostReq, hostRw, hostBurst, hostAckCycle, hostLocked;
	logic [31:0] hostAddr, hostWdata, cardRdata, hostRdata, cardAddr, cardWdata, lastWdata;
	logic [1:0]  hostSize, cardAckWidth, hostResult;
	logic        cardBurstCapable, cardSync, cardError, cardRetry, cardWantBus;
	logic        hostBusy, hostDone, hostGranted, cardWrite, cardOwnsBus, burstSeen, strobeQ;
	logic [2:0]  hostBeat;
	int          fails, comparisons, strobes, s;

	lbt_slot_if slot ();
	lbt_bus_translator lbt_bus_translator_i (.clk(clk), .reset(reset), .hostReq(hostReq),
		.hostAddr(hostAddr), .hostWdata(hostWdata), .hostSize(hostSize), .hostRw(hostRw),
		.hostBurst(hostBurst), .hostAckCycle(hostAckCycle), .hostLocked(hostLocked), .hostBusy(hostBusy),
		.hostDone(hostDone), .hostResult(hostResult), .hostRdata(hostRdata), .hostBeat(hostBeat),
		.hostGranted(hostGranted), .slot(slot));
	lbt_slot_card lbt_slot_card_i (.clk(clk), .reset(reset), .cardRdata(cardRdata),
		.cardBurstCapable(cardBurstCapable), .cardSync(cardSync), .cardAckWidth(cardAckWidth),
		.cardError(cardError), .cardRetry(cardRetry), .cardWantBus(cardWantBus), .cardWrite(cardWrite),
		.cardAddr(cardAddr), .cardWdata(cardWdata), .cardOwnsBus(cardOwnsBus), .slot(slot));
	lbt_checker lbt_checker_i (.clk(clk), .reset(reset), .addr(slot.addr), .rw(slot.rw),
		.strobe_n(slot.strobe_n), .burst_request_n(slot.burst_request_n),
		.async_size_ack_n(slot.async_size_ack_n), .sync_terminate_n(slot.sync_terminate_n),
		.bus_error_n(slot.bus_error_n), .halt_n(slot.halt_n), .fc(slot.fc),
		.cache_inhibit_out_n(slot.cache_inhibit_out_n), .bus_grant_n(slot.bus_grant_n));

	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	// ****************************************
	// Slot monitor
	// ****************************************
	always @(posedge clk) begin
		if (cardWrite === 1'h1) lastWdata <= cardWdata;
		if (strobeQ === 1'h1 && slot.strobe_n === 1'h0) strobes <= strobes + 1;
		strobeQ <= slot.strobe_n;
		if (slot.burst_request_n === 1'h0) burstSeen <= 1'h1;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_of_test;
		if (fails == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Request is dropped after one edge so it is not taken twice
	task automatic host(input logic [31:0] a, d, input logic [1:0] sz, input logic rd, bst, ack);
		int n;
		@(negedge clk);
		{hostAddr, hostWdata, hostSize} = {a, d, sz};
		{hostRw, hostBurst, hostAckCycle, hostReq} = {rd, bst, ack, 1'h1};
		@(negedge clk);
		hostReq = 1'h0;
		if (!ack) chk("busy", 32'h0000_0001, 32'(hostBusy));
		n = 0;
		while (hostDone !== 1'h1) begin
			@(negedge clk);
			n++;
			if (n > 400) begin
				fails++;
				end_of_test();
			end
		end
		chk("busy end", 32'h0000_0000, 32'(hostBusy));
	endtask

	task automatic t_plain;
		cardRdata = 32'h1234_5678;
		host(32'h0000_1000, 32'h0000_0000, lbt_pkg::SIZE_LONG, 1'h1, 1'h0, 1'h0);
		chk("rdata", 32'h1234_5678, hostRdata);
		cardSync = 1'h1;
		host(32'h0000_2000, 32'hCAFE_F00D, lbt_pkg::SIZE_LONG, 1'h0, 1'h0, 1'h0);
		chk("wdata", 32'hCAFE_F00D, lastWdata);
		chk("result", 32'(lbt_pkg::RES_OK), 32'(hostResult));
	endtask

	task automatic t_narrow;
		{cardSync, cardAckWidth, cardRdata} = {1'h0, lbt_pkg::ACK_BYTE, 32'hAB00_0000};
		host(32'h0000_3001, 32'h0000_0000, lbt_pkg::SIZE_BYTE, 1'h1, 1'h0, 1'h0);
		chk("byte lane", 32'h00AB_0000, hostRdata & 32'h00FF_0000);
		host(32'h0000_3003, 32'h0000_005A, lbt_pkg::SIZE_BYTE, 1'h0, 1'h0, 1'h0);
		chk("smear", 32'h5A5A_5A5A, lastWdata);
		{cardAckWidth, cardRdata} = {lbt_pkg::ACK_WORD, 32'h1357_0000};
		s = strobes;
		host(32'h0000_3004, 32'h0000_0000, lbt_pkg::SIZE_LONG, 1'h1, 1'h0, 1'h0);
		chk("word pair", 32'h1357_1357, hostRdata);
		chk("word cycles", 32'(s + 2), 32'(strobes));
		cardAckWidth = lbt_pkg::ACK_LONG;
	endtask

	task automatic t_fault;
		cardError = 1'h1;
		host(32'h0000_4000, 32'h0000_0000, lbt_pkg::SIZE_LONG, 1'h1, 1'h0, 1'h0);
		chk("error", 32'(lbt_pkg::RES_ERROR), 32'(hostResult));
		cardError = 1'h0;
		s = strobes;
		cardRetry = 1'h1;
		fork
			host(32'h0000_5000, 32'h0000_0000, lbt_pkg::SIZE_LONG, 1'h1, 1'h0, 1'h0);
			begin
				repeat (200) begin
					@(negedge clk);
					if (strobes >= s + 10) break;
				end
				cardRetry = 1'h0;
			end
		join
		chk("retried", 32'h0000_0001, 32'(strobes >= s + 10));
		chk("retry result", 32'(lbt_pkg::RES_OK), 32'(hostResult));
		s = strobes;
		host(32'h0000_6000, 32'h0000_0000, lbt_pkg::SIZE_LONG, 1'h1, 1'h0, 1'h1);
		chk("ack cycles", 32'(s), 32'(strobes));
	endtask

	task automatic t_burst;
		{cardBurstCapable, cardSync, burstSeen} = 3'h6;
		host(32'h0400_0000, 32'h0BAD_0001, lbt_pkg::SIZE_LONG, 1'h0, 1'h1, 1'h0);
		chk("burst high", 32'h0000_0000, 32'(burstSeen));
		burstSeen = 1'h0;
		host(32'h0000_0018, 32'h0000_0000, lbt_pkg::SIZE_LONG, 1'h1, 1'h1, 1'h0);
		chk("burst low", 32'h0000_0001, 32'(burstSeen));
		chk("beat", 32'h0000_0003, 32'(hostBeat));
		burstSeen = 1'h0;
		host(32'h0000_0020, 32'h0000_0BAD, lbt_pkg::SIZE_LONG, 1'h0, 1'h1, 1'h0);
		chk("burst write", 32'h0000_0001, 32'(burstSeen));
		chk("write beat", 32'h0000_0003, 32'(hostBeat));
	endtask

	task automatic t_grant;
		int n;
		cardWantBus = 1'h1;
		for (n = 0; n < 100 && hostGranted !== 1'h1; n++) @(negedge clk);
		if (hostGranted !== 1'h1) begin
			fails++;
			end_of_test();
		end
		// The card registers the grant one clock after the translator gives it
		@(negedge clk);
		chk("owns", 32'h0000_0001, 32'(cardOwnsBus));
		cardWantBus = 1'h0;
		for (n = 0; n < 100 && hostGranted !== 1'h0; n++) @(negedge clk);
		chk("released", 32'h0000_0000, 32'(hostGranted));
		if (hostGranted !== 1'h0) end_of_test();
	endtask

	initial begin
		{reset, hostReq, hostRw, hostBurst, hostAckCycle, hostLocked} = 6'h20;
		{hostAddr, hostWdata, hostSize, cardRdata} = 98'h0;
		{cardAckWidth, cardBurstCapable, cardSync, cardError, cardRetry, cardWantBus} = 7'h60;
		{fails, comparisons, strobes, burstSeen, lastWdata} = 0;
		strobeQ = 1'h1;
		repeat (16) @(negedge clk);
		reset = 1'h0;
		t_plain();
		t_narrow();
		t_fault();
		t_burst();
		t_grant();
		end_of_test();
	end
endmodule
